// ===== rtl/asg_if.sv
// interfaces: parameter memory ports and sine lookup ports
interface asg_mem_if;
  logic we;
  logic [1:0] wbe;
  logic [4:0] waddr;
  logic [15:0] wdata;
  logic [4:0] raddr_a;
  logic [15:0] rdata_a;
  logic [4:0] raddr_b;
  logic [15:0] rdata_b;
  modport master(output we, wbe, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport slave(input we, wbe, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : asg_mem_if

interface asg_lut_if;
  logic [15:0] phase;
  logic [15:0] value;
  modport master(output phase, input value);
  modport slave(input phase, output value);
endinterface : asg_lut_if

// ===== rtl/asg_param_mem.sv
// per-channel parameter memory: one write port, two registered read ports
module asg_param_mem
  import asg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  asg_mem_if.slave bus
);
  typedef struct packed {
    logic [31:0][15:0] mem;
    logic [15:0] ra;
    logic [15:0] rb;
  } asg_mem_s;

  asg_mem_s s;
  asg_mem_s n;

  always_comb begin
    n = s;
    n.ra = s.mem[bus.raddr_a];
    n.rb = s.mem[bus.raddr_b];
    if (bus.we) begin
      n.mem[bus.waddr] = merge16(s.mem[bus.waddr], {16'h0000, bus.wdata}, {2'h0, bus.wbe});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.rdata_a = s.ra;
  assign bus.rdata_b = s.rb;
endmodule : asg_param_mem

// ===== rtl/asg_pkg.sv
// package: constants, types and helpers of the angle-synced sine generator
package asg_pkg;
  localparam int CLK_NS = 100;
  localparam int SAMPLE_NS = 100000;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYC - 1);
  localparam int NCH = 8;
  localparam logic [3:0] CNT_MIN = 4'h1;
  localparam logic [3:0] CNT_MAX = 4'h8;
  localparam logic [3:0] CNT_ENC = 4'h2;
  localparam logic [2:0] CH_LAST = 3'h7;
  localparam logic [2:0] CH_COS = 3'h1;
  localparam logic [6:0] PP_MIN = 7'h01;
  localparam logic [6:0] PP_MAX = 7'h40;
  localparam logic [15:0] SLEW_MAX = 16'h03E8;
  localparam longint PHASE_FULL = 64'h1_0000_0000;
  localparam longint DEG_TURN = 360;
  localparam longint NS_PER_S = 1000000000;
  localparam logic [15:0] SLEW_SCALE = 16'(PHASE_FULL * SAMPLE_NS / (DEG_TURN * NS_PER_S));
  localparam logic [15:0] QUARTER = 16'h4000;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GROUP = 8'h04;
  localparam logic [7:0] A_BSIN = 8'h08;
  localparam logic [7:0] A_BCOS = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam int CHAN_BIT = 7;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam int SRC_BIT = 2;
  localparam int CNT_LSB = 4;
  localparam int CNT_W = 4;
  localparam int PP_LSB = 8;
  localparam int PP_W = 7;
  localparam int ST_CH_LSB = 1;
  localparam int ST_ANG_LSB = 16;
  localparam logic [1:0] F_LEVEL = 2'h0;
  localparam logic [1:0] F_GAIN = 2'h1;
  localparam logic [1:0] F_PHASE = 2'h2;
  localparam logic [1:0] F_SLEW = 2'h3;
  localparam int LUT_FRAC_W = 9;
  localparam logic [5:0] LUT_LAST = 6'h20;
  localparam logic [14:0] LUT_QSPAN = 15'h4000;
  localparam logic signed [17:0] SAT_HI = 18'sh07FFF;
  localparam logic signed [17:0] SAT_LO = 18'sh38000;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_SINE = 2'h1,
    MODE_ENC = 2'h2
  } asg_mode_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD = 6'h02,
    ST_CAP = 6'h04,
    ST_CALC = 6'h08,
    ST_MUL = 6'h10,
    ST_DONE = 6'h20
  } asg_state_e;

  localparam asg_mode_e MODE_RST = MODE_DIRECT;
  localparam logic [3:0] CNT_RST = CNT_MAX;
  localparam logic [6:0] PP_RST = PP_MIN;

  // first quadrant of a sine, 33 points, full scale 16'h7FFF
  localparam logic [15:0] SIN_TAB [0:32] = '{
    16'h0000, 16'h0648, 16'h0C8C, 16'h12C8, 16'h18F9, 16'h1F1A, 16'h2528, 16'h2B1F,
    16'h30FB, 16'h36BA, 16'h3C56, 16'h41CE, 16'h471C, 16'h4C3F, 16'h5133, 16'h55F5,
    16'h5A82, 16'h5ED7, 16'h62F1, 16'h66CF, 16'h6A6D, 16'h6DC9, 16'h70E2, 16'h73B5,
    16'h7641, 16'h7884, 16'h7A7C, 16'h7C29, 16'h7D89, 16'h7E9C, 16'h7F61, 16'h7FD8,
    16'h7FFF};

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > SAT_HI) begin
      sat16 = SAT_HI[15:0];
    end else if (v < SAT_LO) begin
      sat16 = SAT_LO[15:0];
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic chan_on(input logic [2:0] ch, input asg_mode_e m,
                                   input logic [3:0] cnt);
    chan_on = ({1'b0, ch} < ((m == MODE_ENC) ? CNT_ENC : cnt));
  endfunction : chan_on
endpackage : asg_pkg

// ===== rtl/asg_sine_lut.sv
// interpolated sine lookup, one cycle from phase to value
module asg_sine_lut
  import asg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  asg_lut_if.slave bus
);
  typedef struct packed {
    logic [15:0] value;
  } asg_lut_s;

  asg_lut_s s;
  asg_lut_s n;
  logic [14:0] idx;
  logic [5:0] i0;
  logic [5:0] i1;
  logic [31:0] step;
  logic [15:0] mag;

  always_comb begin
    n = s;
    // odd quadrants run the table backwards
    idx = bus.phase[14] ? (LUT_QSPAN - {1'b0, bus.phase[13:0]}) : {1'b0, bus.phase[13:0]};
    i0 = idx[14:LUT_FRAC_W];
    i1 = (i0 == LUT_LAST) ? LUT_LAST : i0 + 6'h01;
    step = 32'(SIN_TAB[i1] - SIN_TAB[i0]) * 32'(idx[LUT_FRAC_W-1:0]);
    mag = SIN_TAB[i0] + 16'(step >> LUT_FRAC_W);
    n.value = bus.phase[15] ? 16'(-mag) : mag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.value = s.value;
endmodule : asg_sine_lut

// ===== rtl/asg_top.sv
// angle-synced sine generator: wishbone registers, sequencer and outputs
module asg_top
  import asg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] actual_rotor_angle_i,
  output logic [NCH-1:0][15:0] chan_level_o,
  output logic sample_strobe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    asg_state_e st;
    logic [2:0] ch;
    logic [1:0] fld;
    logic [3:0][15:0] par;
    logic [NCH-1:0][31:0] applied;
    logic [NCH-1:0][15:0] res;
    logic [NCH-1:0][15:0] out;
    logic strobe;
    logic [DIV_W-1:0] div;
    logic tick_pend;
    asg_mode_e mode;
    logic src;
    logic [3:0] count;
    logic [6:0] pp;
    logic [15:0] group_phase_offset;
    logic [15:0] encoder_sin_bias;
    logic [15:0] encoder_cos_bias;
    logic wb_wait;
    logic ack;
    logic [31:0] dat;
  } asg_top_s;

  asg_top_s s;
  asg_top_s n;

  asg_mem_if mem_bus();
  asg_lut_if lut_bus();

  logic req;
  logic mem_we;
  logic [15:0] ctrl16;
  logic [15:0] wv;
  logic [31:0] rdat;
  logic [3:0] cv;
  logic [6:0] pv;
  logic [31:0] tgt;
  logic [31:0] diff;
  logic [31:0] dmag;
  logic [31:0] step;
  logic [15:0] rate;
  logic [31:0] app;
  logic [15:0] theta;
  logic signed [32:0] prod;
  logic signed [17:0] enc_sum;
  logic [15:0] sample;

  ////////////////////////////////////////////////////////////////////////////
  // leaves

  asg_param_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(mem_bus.slave)
  );

  asg_sine_lut u_lut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(lut_bus.slave)
  );

  assign mem_bus.raddr_a = {s.ch, s.fld};
  assign mem_bus.raddr_b = wb_adr_i[6:2];
  assign mem_bus.waddr = wb_adr_i[6:2];
  assign mem_bus.wdata = wb_dat_i[15:0];
  assign mem_bus.wbe = wb_sel_i[1:0];
  assign mem_bus.we = mem_we;
  assign lut_bus.phase = theta;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s;
    n.strobe = 1'b0;
    n.ack = 1'b0;
    n.wb_wait = 1'b0;
    mem_we = 1'b0;
    rdat = '0;
    wv = '0;
    cv = '0;
    pv = '0;
    tgt = '0;
    diff = '0;
    dmag = '0;
    step = '0;
    rate = '0;
    app = '0;
    theta = '0;
    prod = '0;
    enc_sum = '0;
    sample = '0;

    ctrl16 = '0;
    ctrl16[MODE_LSB +: MODE_W] = s.mode;
    ctrl16[SRC_BIT] = s.src;
    ctrl16[CNT_LSB +: CNT_W] = s.count;
    ctrl16[PP_LSB +: PP_W] = s.pp;

    // bus: first cycle waits for the memory read, second answers
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    if (req & ~s.wb_wait) begin
      n.wb_wait = 1'b1;
    end else if (req) begin
      n.ack = 1'b1;
      if (wb_adr_i[CHAN_BIT]) begin
        // registers of inactive channels read zero and ignore writes
        if (chan_on(wb_adr_i[6:4], s.mode, s.count)) begin
          rdat = {16'h0000, mem_bus.rdata_b};
          mem_we = wb_we_i;
        end
      end else if (wb_adr_i == A_CTRL) begin
        rdat = {16'h0000, ctrl16};
        if (wb_we_i) begin
          wv = merge16(ctrl16, wb_dat_i, wb_sel_i);
          if (wv[MODE_LSB +: MODE_W] == MODE_SINE) begin
            n.mode = MODE_SINE;
          end else if (wv[MODE_LSB +: MODE_W] == MODE_ENC) begin
            n.mode = MODE_ENC;
          end else begin
            n.mode = MODE_DIRECT;
          end
          n.src = wv[SRC_BIT];
          cv = wv[CNT_LSB +: CNT_W];
          if (cv < CNT_MIN) begin
            cv = CNT_MIN;
          end else if (cv > CNT_MAX) begin
            cv = CNT_MAX;
          end
          n.count = cv;
          pv = wv[PP_LSB +: PP_W];
          if (pv < PP_MIN) begin
            pv = PP_MIN;
          end else if (pv > PP_MAX) begin
            pv = PP_MAX;
          end
          n.pp = pv;
        end
      end else if (wb_adr_i == A_GROUP) begin
        rdat = {16'h0000, s.group_phase_offset};
        if (wb_we_i) begin
          n.group_phase_offset = merge16(s.group_phase_offset, wb_dat_i, wb_sel_i);
        end
      end else if (wb_adr_i == A_BSIN) begin
        rdat = {16'h0000, s.encoder_sin_bias};
        if (wb_we_i) begin
          n.encoder_sin_bias = merge16(s.encoder_sin_bias, wb_dat_i, wb_sel_i);
        end
      end else if (wb_adr_i == A_BCOS) begin
        rdat = {16'h0000, s.encoder_cos_bias};
        if (wb_we_i) begin
          n.encoder_cos_bias = merge16(s.encoder_cos_bias, wb_dat_i, wb_sel_i);
        end
      end else if (wb_adr_i == A_STAT) begin
        rdat[0] = (s.st != ST_IDLE);
        rdat[ST_CH_LSB +: 3] = s.ch;
        rdat[ST_ANG_LSB +: 16] = actual_rotor_angle_i;
      end
      n.dat = wb_we_i ? '0 : rdat;
    end

    // sequencer: walks all channels once per sample tick
    case (s.st)
      ST_IDLE: begin
        if (s.tick_pend) begin
          n.tick_pend = 1'b0;
          n.ch = '0;
          n.fld = F_LEVEL;
          n.st = ST_RD;
        end
      end
      ST_RD: begin
        n.st = ST_CAP;
      end
      ST_CAP: begin
        n.par[s.fld] = mem_bus.rdata_a;
        if (s.fld == F_SLEW) begin
          n.st = ST_CALC;
        end else begin
          n.fld = s.fld + 2'h1;
          n.st = ST_RD;
        end
      end
      ST_CALC: begin
        // fractional accumulator: one degree per second is far below one lsb per sample
        tgt = {s.par[F_PHASE], 16'h0000};
        rate = (s.par[F_SLEW] > SLEW_MAX) ? SLEW_MAX : s.par[F_SLEW];
        step = 32'(rate) * 32'(SLEW_SCALE);
        // modular difference takes the short way round the circle
        diff = tgt - s.applied[s.ch];
        dmag = diff[31] ? 32'(-diff) : diff;
        if (rate == 16'h0000 || dmag <= step) begin
          app = tgt;
        end else if (diff[31]) begin
          app = s.applied[s.ch] - step;
        end else begin
          app = s.applied[s.ch] + step;
        end
        n.applied[s.ch] = app;
        // electrical angle wraps modulo one turn, so the low bits suffice
        theta = 16'(s.pp * actual_rotor_angle_i) + app[31:16];
        if (s.src) begin
          theta = theta + s.group_phase_offset;
        end
        if (s.mode == MODE_ENC && s.ch == CH_COS) begin
          theta = theta + QUARTER;
        end
        n.st = ST_MUL;
      end
      ST_MUL: begin
        prod = $signed({1'b0, s.par[F_GAIN]}) * $signed(lut_bus.value);
        sample = prod[31:16];
        if (!chan_on(s.ch, s.mode, s.count)) begin
          n.res[s.ch] = '0;
        end else if (s.mode == MODE_DIRECT) begin
          n.res[s.ch] = s.par[F_LEVEL];
        end else if (s.mode == MODE_ENC) begin
          enc_sum = 18'($signed(sample)) + 18'($signed(
                    (s.ch == CH_COS) ? s.encoder_cos_bias : s.encoder_sin_bias));
          n.res[s.ch] = sat16(enc_sum);
        end else begin
          n.res[s.ch] = sample;
        end
        if (s.ch == CH_LAST) begin
          n.st = ST_DONE;
        end else begin
          n.ch = s.ch + 3'h1;
          n.fld = F_LEVEL;
          n.st = ST_RD;
        end
      end
      ST_DONE: begin
        // all channels change together so a group shift lands in one sample
        n.out = s.res;
        n.strobe = 1'b1;
        n.st = ST_IDLE;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // sample-rate divider; placed last so a tick is never lost to the clear above
    if (s.div == DIV_LAST) begin
      n.div = '0;
      n.tick_pend = 1'b1;
    end else begin
      n.div = s.div + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.mode <= MODE_RST;
      s.count <= CNT_RST;
      s.pp <= PP_RST;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign chan_level_o = s.out;
  assign sample_strobe_o = s.strobe;
endmodule : asg_top

// ===== test/asg_checker.sv
// port checks of the generator
module asg_checker
  import asg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] actual_rotor_angle_i,
  input wire logic [NCH-1:0][15:0] chan_level_o,
  input wire logic sample_strobe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] gap_reg;
  logic seen_reg;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a counter spares a thousand-cycle repetition
  always_ff @(posedge clk_i) begin
    gap_reg <= (rst_i || sample_strobe_o) ? 10'h000 : gap_reg + 10'h001;
    seen_reg <= rst_i ? 1'b0 : (seen_reg || sample_strobe_o);
  end
  property p_ack_lat;
    $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##[1:2] wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_stb_i, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack uncaused");
  property p_wr_zero;
    wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data out");
  property p_rd_angle;
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == A_STAT[7:2] |->
      wb_dat_o[31:16] == actual_rotor_angle_i;
  endproperty
  a_rd_angle: assert property (p_rd_angle) else $error("angle readback");
  property p_period;
    sample_strobe_o && seen_reg |-> gap_reg == 10'(SAMPLE_CYC - 1);
  endproperty
  a_period: assert property (p_period) else $error("sample spacing");
  property p_hold;
    !sample_strobe_o |-> $stable(chan_level_o);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_strobe;
    sample_strobe_o |=> !sample_strobe_o [*8];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
endmodule : asg_checker

bind asg_top asg_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .actual_rotor_angle_i, .chan_level_o, .sample_strobe_o);

// ===== test/asg_dac_model.sv
// output stage model: latches the channel levels on each sample strobe
module asg_dac_model
  import asg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NCH-1:0][15:0] level_i,
  input wire logic strobe_i,
  output logic [NCH-1:0][15:0] held_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // levels stay relative here; scaling by the reference is left out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_o <= '0;
    end else if (strobe_i) begin
      held_o <= level_i;
    end
  end
endmodule : asg_dac_model

// ===== test/testbench.sv
// self-checking bench of the generator
module testbench
  import asg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h3;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] ang = 16'h0000;
  logic [31:0] rdat;
  logic ack;
  logic strb;
  logic [NCH-1:0][15:0] lvl;
  logic [NCH-1:0][15:0] held;
  logic [31:0] q;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  asg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .actual_rotor_angle_i(ang), .chan_level_o(lvl), .sample_strobe_o(strb));
  asg_dac_model dac (.clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .strobe_i(strb),
    .held_o(held));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg
  task automatic cmp_lvl(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_lvl
  // waits for ack with no limit of its own; only the bench timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // waits for k strobes; the bench timeout cuts a hang short
  task automatic samples(input int k);
    repeat (k) begin
      do @(posedge clk_i); while (strb !== 1'b1);
    end
    @(posedge clk_i);
  endtask : samples
  function automatic logic [7:0] cad(input int ch, input logic [1:0] f);
    return 8'h80 + 8'(ch * 16) + {4'h0, f, 2'h0};
  endfunction : cad
  function automatic logic [15:0] ctl(input asg_mode_e m, input logic s,
                                      input logic [3:0] c, input logic [6:0] p);
    return {1'b0, p, c, 1'b0, s, m};
  endfunction : ctl
  function automatic logic [15:0] dlev(input int ch);
    return (ch == 0) ? 16'h7FFF : (ch == 1) ? 16'h8000 : 16'(ch * 16'h1357);
  endfunction : dlev
  // gain times a table point, same scaling as the output path
  function automatic logic [15:0] exs(input logic [15:0] g, input int i);
    return 16'((32'(g) * 32'(SIN_TAB[i])) >> 16);
  endfunction : exs
  task automatic chan(input int ch, input logic [15:0] g, input logic [15:0] p,
                      input logic [15:0] s);
    wb(1'b1, cad(ch, F_GAIN), g);
    wb(1'b1, cad(ch, F_PHASE), p);
    wb(1'b1, cad(ch, F_SLEW), s);
  endtask : chan
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1'b0, A_CTRL, 16'h0);
    cmp_reg("ctrl reset", 32'h0000_0180, q);
    cmp_lvl("level reset", 16'h0000, lvl[0]);
    wb(1'b1, 8'h20, 16'hABCD);
    wb(1'b0, 8'h20, 16'h0);
    cmp_reg("unmapped", 32'h0, q);
    ang <= 16'h1357;
    wb(1'b0, A_STAT, 16'h0);
    cmp_reg("status angle", 32'h1357, {16'h0, q[31:16]});
    wb(1'b1, cad(2, F_PHASE), 16'h8001);
    wb(1'b0, cad(2, F_PHASE), 16'h0);
    cmp_reg("phase readback", 32'h8001, q);
    $display("test regs done");
  endtask : t_regs
  task automatic t_direct();
    for (int ch = 0; ch < 8; ch++) wb(1'b1, cad(ch, F_LEVEL), dlev(ch));
    samples(2);
    for (int ch = 0; ch < 8; ch++) cmp_lvl("direct", dlev(ch), held[ch]);
    $display("test direct done");
  endtask : t_direct
  task automatic t_count();
    wb(1'b1, A_CTRL, ctl(MODE_DIRECT, 1'b0, 4'h3, 7'h01));
    wb(1'b1, cad(5, F_LEVEL), 16'h5555);
    wb(1'b0, cad(5, F_LEVEL), 16'h0);
    cmp_reg("inactive reg", 32'h0, q);
    samples(2);
    for (int ch = 0; ch < 8; ch++) cmp_lvl("count", ch < 3 ? dlev(ch) : 16'h0, held[ch]);
    wb(1'b1, A_CTRL, ctl(MODE_DIRECT, 1'b0, 4'h0, 7'h7F));
    wb(1'b0, A_CTRL, 16'h0);
    cmp_reg("clamp a", {16'h0, ctl(MODE_DIRECT, 1'b0, CNT_MIN, PP_MAX)}, q);
    wb(1'b1, A_CTRL, ctl(MODE_DIRECT, 1'b0, 4'hF, 7'h00));
    wb(1'b0, A_CTRL, 16'h0);
    cmp_reg("clamp b", {16'h0, ctl(MODE_DIRECT, 1'b0, CNT_MAX, PP_MIN)}, q);
    $display("test count done");
  endtask : t_count
  task automatic t_sine();
    chan(0, 16'hFFFF, 16'h0, 16'h0);
    chan(1, 16'h8000, 16'h0, 16'h0);
    ang <= 16'h2000;
    for (int p = 1; p <= 2; p++) begin
      wb(1'b1, A_CTRL, ctl(MODE_SINE, 1'b0, 4'h2, 7'(p)));
      samples(2);
      cmp_lvl("sine0", exs(16'hFFFF, 16 * p), held[0]);
      cmp_lvl("sine1", exs(16'h8000, 16 * p), held[1]);
      cmp_lvl("sine off", 16'h0, held[2]);
    end
    $display("test sine done");
  endtask : t_sine
  task automatic t_group();
    ang <= 16'h0000;
    wb(1'b1, A_GROUP, 16'h2000);
    wb(1'b1, cad(0, F_PHASE), 16'h2000);
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, A_CTRL, ctl(MODE_SINE, 1'(s), 4'h2, 7'h01));
      samples(2);
      cmp_lvl("group", exs(16'hFFFF, 16 + 16 * s), held[0]);
    end
    $display("test group done");
  endtask : t_group
  task automatic t_slew();
    wb(1'b1, A_CTRL, ctl(MODE_SINE, 1'b0, 4'h2, 7'h01));
    wb(1'b1, cad(0, F_PHASE), 16'h0);
    samples(2);
    wb(1'b1, cad(0, F_SLEW), SLEW_MAX);
    wb(1'b1, cad(0, F_PHASE), 16'h4000);
    samples(2);
    cmp_reg("slewing", 32'h1, {31'h0, held[0] > 16'h0 && held[0] < 16'h0200});
    wb(1'b1, cad(0, F_SLEW), 16'h0);
    samples(2);
    cmp_lvl("jump", exs(16'hFFFF, 32), held[0]);
    $display("test slew done");
  endtask : t_slew
  task automatic t_enc();
    wb(1'b1, A_CTRL, ctl(MODE_ENC, 1'b0, 4'h8, 7'h01));
    chan(0, 16'h8000, 16'h0, 16'h0);
    chan(1, 16'h8000, 16'h0, 16'h0);
    wb(1'b1, A_BSIN, 16'h6000);
    wb(1'b1, A_BCOS, 16'h6000);
    samples(2);
    cmp_lvl("enc sin", 16'h6000, held[0]);
    cmp_lvl("enc cos sat", SAT_HI[15:0], held[1]);
    cmp_lvl("enc other", 16'h0, held[2]);
    wb(1'b1, cad(0, F_PHASE), 16'hC000);
    wb(1'b1, A_BSIN, 16'h8000);
    samples(2);
    cmp_lvl("enc sin sat", SAT_LO[15:0], held[0]);
    $display("test enc done");
  endtask : t_enc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever begin
      @(posedge clk_i);
      cycles++;
      if (cycles == 40000) begin
        mismatches++;
        end_of_test();
      end
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_direct();
    t_count();
    t_sine();
    t_group();
    t_slew();
    t_enc();
    end_of_test();
  end
endmodule : testbench
